// ===== hdl/wdc_pkg.sv
// What this block does
// - Power-on flag is set by power-up and clears only by software write.
// - Power-on flag is readable and writable; a write is its only clear.
// - Timeout sets the timeout flag; software clears it.
// - Timeout flag is set on timeout even with the interrupt disabled.
// - Watchdog reset sets the reset-cause flag; software, power-on or power-fail reset clears it.
// - Power-fail reset clears the reset-cause flag.
// - With reset enable zero the watchdog never touches the reset-cause flag.
// - Reset-enable bit arms the watchdog reset; clear means no reset.
// - Writing one to restart puts the counter back to its start.
// - Restart bit clears itself in hardware.
// - Timeout raises the interrupt when the interrupt enable bit is set.
// - With reset enable set, reset follows 512 clocks after timeout unless restarted.
// - External reset loads control register with 0x0x0xx0b, x bits kept.
// - Watchdog reset sets reset-cause to 1; power-on and power-down clear it.
// - External reset leaves the reset-cause flag unchanged.
// - Power-on reset clears reset enable; other resets leave it.
// - Power-on, reset enable, timeout and restart bits need an open window.
// - All control bits readable; the other bits write freely.
// - Both top clock control bits set select the 26-bit timeout.
// - Priority register holds the watchdog interrupt priority bit.
// - Unlock is a write of AAh then, next, a write of 55h to the key.
// - After unlock, protected writes are accepted for three machine cycles.
package wdc_pkg;
	localparam int ADDR_W = 10;
	localparam logic [7:0] CTRL_IDX = 8'hd8;
	localparam logic [7:0] KEY_IDX = 8'hc7;
	localparam logic [7:0] CLKCTL_IDX = 8'h8e;
	localparam logic [7:0] IRQEN_IDX = 8'he8;
	localparam logic [7:0] IRQPRI_IDX = 8'hf8;
	localparam int BIT_POR = 6;
	localparam int BIT_TOUT_FLAG = 3;
	localparam int BIT_CAUSE = 2;
	localparam int BIT_RST_EN = 1;
	localparam int BIT_RESTART = 0;
	localparam int BIT_IRQ_EN = 4;
	localparam int BIT_IRQ_PRI = 4;
	localparam int CK_SEL_HI = 7;
	localparam int CK_SEL_LO = 6;
	localparam logic [7:0] KEY_FIRST = 8'haa;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	localparam logic [7:0] PROT_MASK = 8'h4b;
	localparam logic [7:0] EXT_KEEP_MASK = 8'h56;
	localparam logic [7:0] EXT_LOAD_VAL = 8'h00;
	localparam logic [7:0] CLKCTL_RST = 8'h01;
	localparam logic [7:0] IRQPRI_IMPL_MASK = 8'h1f;
	localparam int MC_CLKS = 4;
	localparam int WIN_MC = 3;
	localparam int WIN_CLKS = MC_CLKS * WIN_MC;
	localparam logic [3:0] WIN_LOAD = 4'(WIN_CLKS - 1);
	localparam int RST_DELAY_CLKS = 512;
	localparam logic [9:0] RST_DELAY_LAST = 10'(RST_DELAY_CLKS - 1);
	localparam int WD_W = 26;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_ARMED = 2'b01,
		KEY_OPEN = 2'b10
	} wdc_key_state_t;
endpackage

// ===== hdl/wdc_top.sv
`timescale 1ns/1ns
`default_nettype none
module wdc_top #(
	parameter int TOUT_BITS_0 = 17,
	parameter int TOUT_BITS_1 = 20,
	parameter int TOUT_BITS_2 = 23,
	parameter int TOUT_BITS_3 = 26
) (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic EXT_RST_IN,
	input wire logic PFAIL_RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [wdc_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic WDOG_IRQ_OUT,
	output logic WDOG_IRQ_PRIO_OUT,
	output logic WDOG_RST_OUT
);

	function automatic logic reg_hit(input logic [wdc_pkg::ADDR_W-1:0] addr,
		input logic [7:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic [wdc_pkg::WD_W-1:0] tout_limit(input logic [1:0] sel);
		logic [wdc_pkg::WD_W:0] one;
		one = {{wdc_pkg::WD_W{1'b0}}, 1'b1};
		case (sel)
			2'b00: tout_limit = wdc_pkg::WD_W'((one << TOUT_BITS_0) - 1'b1);
			2'b01: tout_limit = wdc_pkg::WD_W'((one << TOUT_BITS_1) - 1'b1);
			2'b10: tout_limit = wdc_pkg::WD_W'((one << TOUT_BITS_2) - 1'b1);
			default: tout_limit = wdc_pkg::WD_W'((one << TOUT_BITS_3) - 1'b1);
		endcase
	endfunction

	logic ext_s1_q;
	logic ext_s2_q;
	logic pf_s1_q;
	logic pf_s2_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] ctrl_q;
	logic [7:0] clkctl_q;
	logic [7:0] irqen_q;
	logic [7:0] irqpri_q;
	wdc_pkg::wdc_key_state_t key_state_q;
	logic [3:0] win_cnt_q;
	logic [wdc_pkg::WD_W-1:0] wd_cnt_q;
	logic post_q;
	logic [9:0] post_cnt_q;
	logic wd_rst_q;
	logic irq_q;
	logic prio_q;
	logic access_done;
	logic wr_done;
	logic mapped;
	logic wr_ctrl;
	logic wr_key;
	logic win_open;
	logic restart;
	logic timeout;
	logic wd_reset_ev;
	logic [7:0] wmask;
	logic [7:0] wdata;

	// Bus handshake
	assign access_done = PSEL_IN && PENABLE_IN && pready_q;
	assign wr_done = access_done && PWRITE_IN;
	assign wdata = PWDATA_IN[7:0];
	assign mapped = reg_hit(PADDR_IN, wdc_pkg::CTRL_IDX) || reg_hit(PADDR_IN, wdc_pkg::KEY_IDX)
		|| reg_hit(PADDR_IN, wdc_pkg::CLKCTL_IDX) || reg_hit(PADDR_IN, wdc_pkg::IRQEN_IDX)
		|| reg_hit(PADDR_IN, wdc_pkg::IRQPRI_IDX);
	assign wr_ctrl = wr_done && reg_hit(PADDR_IN, wdc_pkg::CTRL_IDX);
	assign wr_key = wr_done && reg_hit(PADDR_IN, wdc_pkg::KEY_IDX);
	assign win_open = (key_state_q == wdc_pkg::KEY_OPEN);
	assign wmask = win_open ? 8'hff : ~wdc_pkg::PROT_MASK;
	assign restart = wr_ctrl && wmask[wdc_pkg::BIT_RESTART] && wdata[wdc_pkg::BIT_RESTART];
	// At or past the limit, so a shorter length chosen mid-count still times out at once
	assign timeout = (wd_cnt_q >= tout_limit(clkctl_q[wdc_pkg::CK_SEL_HI:wdc_pkg::CK_SEL_LO]));
	assign wd_reset_ev = post_q && (post_cnt_q == wdc_pkg::RST_DELAY_LAST)
		&& ctrl_q[wdc_pkg::BIT_RST_EN];

	// Reset pin synchronisers
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			pf_s1_q <= 1'b0;
			pf_s2_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= EXT_RST_IN;
			ext_s2_q <= ext_s1_q;
			pf_s1_q <= PFAIL_RST_IN;
			pf_s2_q <= pf_s1_q;
		end
	end

	// Bus slave: one wait state, then ready with data
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= PSEL_IN && PENABLE_IN && !pready_q;
			pslverr_q <= PSEL_IN && PENABLE_IN && !pready_q && !mapped;
			prdata_q <= 32'h0000_0000;
			if (PSEL_IN && PENABLE_IN && !pready_q && !PWRITE_IN)
			begin
				if (reg_hit(PADDR_IN, wdc_pkg::CTRL_IDX))
					prdata_q <= {24'h00_0000, ctrl_q};
				else if (reg_hit(PADDR_IN, wdc_pkg::CLKCTL_IDX))
					prdata_q <= {24'h00_0000, clkctl_q};
				else if (reg_hit(PADDR_IN, wdc_pkg::IRQEN_IDX))
					prdata_q <= {24'h00_0000, irqen_q};
				else if (reg_hit(PADDR_IN, wdc_pkg::IRQPRI_IDX))
					prdata_q <= {24'h00_0000, irqpri_q};
				else
					prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Timed-access unlock sequence and window
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			key_state_q <= wdc_pkg::KEY_IDLE;
			win_cnt_q <= 4'h0;
		end
		else if (wr_key && wdata == wdc_pkg::KEY_FIRST)
		begin
			key_state_q <= wdc_pkg::KEY_ARMED;
			win_cnt_q <= 4'h0;
		end
		else
		begin
			case (key_state_q)
				wdc_pkg::KEY_ARMED:
				begin
					if (wr_key && wdata == wdc_pkg::KEY_SECOND)
					begin
						key_state_q <= wdc_pkg::KEY_OPEN;
						win_cnt_q <= wdc_pkg::WIN_LOAD;
					end
					else if (wr_done)
						key_state_q <= wdc_pkg::KEY_IDLE;
				end
				wdc_pkg::KEY_OPEN:
				begin
					if (win_cnt_q == 4'h0)
						key_state_q <= wdc_pkg::KEY_IDLE;
					else
						win_cnt_q <= win_cnt_q - 4'h1;
				end
				default:
					key_state_q <= wdc_pkg::KEY_IDLE;
			endcase
		end
	end

	// Other registers: clock control and interrupt enable / priority
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			clkctl_q <= wdc_pkg::CLKCTL_RST;
			irqen_q <= 8'h00;
			irqpri_q <= 8'h00;
		end
		else if (wr_done)
		begin
			if (reg_hit(PADDR_IN, wdc_pkg::CLKCTL_IDX))
				clkctl_q <= wdata;
			if (reg_hit(PADDR_IN, wdc_pkg::IRQEN_IDX))
				irqen_q <= wdata;
			if (reg_hit(PADDR_IN, wdc_pkg::IRQPRI_IDX))
				irqpri_q <= wdata & wdc_pkg::IRQPRI_IMPL_MASK;
		end
	end

	// Watchdog counter and post-timeout delay
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			wd_cnt_q <= '0;
			post_q <= 1'b0;
			post_cnt_q <= 10'h000;
			wd_rst_q <= 1'b0;
		end
		else if (restart || ext_s2_q || pf_s2_q || wd_reset_ev)
		begin
			wd_cnt_q <= '0;
			post_q <= 1'b0;
			post_cnt_q <= 10'h000;
			wd_rst_q <= wd_reset_ev;
		end
		else
		begin
			wd_rst_q <= 1'b0;
			wd_cnt_q <= timeout ? '0 : wd_cnt_q + 1'b1;
			if (timeout && !post_q)
			begin
				post_q <= 1'b1;
				post_cnt_q <= 10'h000;
			end
			else if (post_q)
				post_cnt_q <= post_cnt_q + 10'h001;
		end
	end

	// Watchdog control register
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			ctrl_q <= 8'h00;
			ctrl_q[wdc_pkg::BIT_POR] <= 1'b1;
			ctrl_q[wdc_pkg::BIT_RST_EN] <= 1'b0;
			ctrl_q[wdc_pkg::BIT_CAUSE] <= 1'b0;
		end
		else if (ext_s2_q || pf_s2_q || wd_reset_ev)
		begin
			ctrl_q <= (ctrl_q & wdc_pkg::EXT_KEEP_MASK)
				| (wdc_pkg::EXT_LOAD_VAL & ~wdc_pkg::EXT_KEEP_MASK);
			if (pf_s2_q)
				ctrl_q[wdc_pkg::BIT_CAUSE] <= 1'b0;
			else if (wd_reset_ev)
				ctrl_q[wdc_pkg::BIT_CAUSE] <= 1'b1;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= (ctrl_q & ~wmask) | (wdata & wmask);
			ctrl_q[wdc_pkg::BIT_RESTART] <= 1'b0;
			if (wr_ctrl && wmask[wdc_pkg::BIT_RESTART])
				ctrl_q[wdc_pkg::BIT_RESTART] <= wdata[wdc_pkg::BIT_RESTART];
			if (ctrl_q[wdc_pkg::BIT_RESTART])
				ctrl_q[wdc_pkg::BIT_RESTART] <= 1'b0;
			if (timeout)
				ctrl_q[wdc_pkg::BIT_TOUT_FLAG] <= 1'b1;
		end
	end

	// Interrupt request and priority outputs
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			irq_q <= 1'b0;
			prio_q <= 1'b0;
		end
		else
		begin
			irq_q <= ctrl_q[wdc_pkg::BIT_TOUT_FLAG] && irqen_q[wdc_pkg::BIT_IRQ_EN];
			prio_q <= irqpri_q[wdc_pkg::BIT_IRQ_PRI];
		end
	end

	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = pslverr_q;
	assign WDOG_IRQ_OUT = irq_q;
	assign WDOG_IRQ_PRIO_OUT = prio_q;
	assign WDOG_RST_OUT = wd_rst_q;

endmodule
`default_nettype wire

// ===== bench/wdc_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module wdc_checker (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [wdc_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic WDOG_IRQ_PRIO_OUT,
	input wire logic WDOG_RST_OUT
);
	logic mapped;
	logic wr_prio;
	assign mapped = PADDR_IN inside {10'h360, 10'h31c, 10'h238, 10'h3a0, 10'h3e0};
	assign wr_prio = PREADY_OUT && PWRITE_IN && PADDR_IN == 10'h3e0;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);
	sequence s_setup;
		PSEL_IN && !PENABLE_IN;
	endsequence
	sequence s_access;
		PSEL_IN && PENABLE_IN;
	endsequence
	a_ready_one_wait: assert property (s_setup ##1 s_access |=> PREADY_OUT)
		else $error("answer not in second access cycle");
	a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN && $past(PSEL_IN && PENABLE_IN))
		else $error("ready without access");
	a_err_decode: assert property (PREADY_OUT |-> PSLVERR_OUT == !mapped)
		else $error("error response wrong");
	a_rdata_clean: assert property (PRDATA_OUT[31:8] == 24'h0 && (PREADY_OUT || PRDATA_OUT == 32'h0))
		else $error("read data not clean");
	a_key_reads_zero: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 10'h31c |-> PRDATA_OUT == 32'h0)
		else $error("key register readable");
	a_prio_bits: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 10'h3e0 |-> PRDATA_OUT[7:5] == 3'h0)
		else $error("reserved priority bits set");
	a_prio_cause: assert property ($changed(WDOG_IRQ_PRIO_OUT) |-> $past(wr_prio) || $past(wr_prio, 2))
		else $error("priority moved without write");
	a_rst_spacing: assert property (WDOG_RST_OUT |=> !WDOG_RST_OUT [*8])
		else $error("reset pulses too close");
endmodule
bind wdc_top wdc_checker u_wdc_checker (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .WDOG_IRQ_PRIO_OUT(WDOG_IRQ_PRIO_OUT),
	.WDOG_RST_OUT(WDOG_RST_OUT));
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [9:0] A_WD = {wdc_pkg::CTRL_IDX, 2'b00};
	localparam logic [9:0] A_KEY = {wdc_pkg::KEY_IDX, 2'b00};
	localparam logic [9:0] A_CK = {wdc_pkg::CLKCTL_IDX, 2'b00};
	localparam logic [9:0] A_IE = {wdc_pkg::IRQEN_IDX, 2'b00};
	localparam logic [9:0] A_IP = {wdc_pkg::IRQPRI_IDX, 2'b00};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ext = 1'b0;
	logic pfail = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [9:0] paddr = 10'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic perr;
	logic irq;
	logic prio;
	logic wrst;
	logic [7:0] rd;
	logic er;
	int err_total = 0;
	int checks_done = 0;
	int rst_seen = 0;
	int base;
	int n;
	always #4 clk = ~clk;
	always @(posedge clk)
		rst_seen <= rst_seen + int'(wrst === 1'b1);
	wdc_top #(.TOUT_BITS_0(14), .TOUT_BITS_1(4), .TOUT_BITS_2(5), .TOUT_BITS_3(6)) u_wdc_top (
		.CLOCK_IN(clk), .RSTN_IN(rstn), .EXT_RST_IN(ext), .PFAIL_RST_IN(pfail),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
		.WDOG_IRQ_OUT(irq), .WDOG_IRQ_PRIO_OUT(prio), .WDOG_RST_OUT(wrst));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic pause(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata[7:0];
		er = perr;
		chk(32'(pready), 32'h1);
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(32'(rd & m), 32'(e));
	endtask
	task automatic unlock;
		apb(1'b1, A_KEY, wdc_pkg::KEY_FIRST);
		apb(1'b1, A_KEY, wdc_pkg::KEY_SECOND);
	endtask
	task automatic t_defaults;
		rchk(A_WD, 8'hff, 8'h40);
		rchk(A_CK, 8'hff, 8'h01);
		rchk(A_IP, 8'hff, 8'h00);
		rchk(10'h004, 8'hff, 8'h00);
		chk(32'(er), 32'h1);
	endtask
	task automatic t_access;
		apb(1'b1, A_WD, 8'hff);
		rchk(A_WD, 8'hff, 8'hf4);
		unlock();
		apb(1'b1, A_WD, 8'h00);
		rchk(A_WD, 8'hff, 8'h00);
		apb(1'b1, A_KEY, wdc_pkg::KEY_FIRST);
		apb(1'b1, A_CK, 8'h01);
		apb(1'b1, A_KEY, wdc_pkg::KEY_SECOND);
		apb(1'b1, A_WD, 8'h40);
		rchk(A_WD, 8'hff, 8'h00);
		unlock();
		pause(12);
		apb(1'b1, A_WD, 8'h40);
		rchk(A_WD, 8'hff, 8'h00);
	endtask
	task automatic t_timeout;
		apb(1'b1, A_IE, 8'h10);
		apb(1'b1, A_IP, 8'h10);
		pause(3);
		chk(32'(prio), 32'h1);
		apb(1'b1, A_CK, 8'h41);
		for (n = 0; irq !== 1'b1 && n < 40; n++)
			@(posedge clk);
		chk(32'(irq), 32'h1);
		rchk(A_WD, 8'hff, 8'h08);
		apb(1'b1, A_IE, 8'h00);
		unlock();
		apb(1'b1, A_WD, 8'h00);
		pause(20);
		chk(32'(irq), 32'h0);
		rchk(A_WD, 8'hff, 8'h08);
	endtask
	task automatic t_wdreset;
		base = rst_seen;
		repeat (60)
		begin
			unlock();
			apb(1'b1, A_WD, 8'h03);
		end
		chk(32'(rst_seen - base), 32'h0);
		for (n = 0; rst_seen == base && n < 700; n++)
			@(posedge clk);
		chk(32'(n >= 524 && n <= 538), 32'h1);
		rchk(A_WD, 8'hf7, 8'h06);
		unlock();
		apb(1'b1, A_WD, 8'h04);
		base = rst_seen;
		pause(700);
		chk(32'(rst_seen - base), 32'h0);
		rchk(A_WD, 8'hf7, 8'h04);
	endtask
	task automatic t_resets;
		unlock();
		apb(1'b1, A_WD, 8'hf6);
		ext <= 1'b1;
		pause(6);
		ext <= 1'b0;
		pause(4);
		rchk(A_WD, 8'hf7, 8'h56);
		pfail <= 1'b1;
		pause(6);
		pfail <= 1'b0;
		pause(4);
		rchk(A_WD, 8'hf7, 8'h52);
	endtask
	initial
	begin
		pause(8);
		rstn <= 1'b1;
		t_defaults();
		t_access();
		t_timeout();
		t_wdreset();
		t_resets();
		report_and_stop();
	end
	initial
	begin
		#160000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
